// ### srap_pkg.sv
package srap_pkg;

  localparam int unsigned SRAP_WORD_W = 16;
  localparam int unsigned SRAP_ADDR_W = 10;

  // Command word layout
  localparam int unsigned SRAP_CMD_EN_HI = 15;
  localparam int unsigned SRAP_CMD_EN_LO = 11;
  localparam int unsigned SRAP_CMD_DIR_BIT = 10;
  localparam logic [4:0] SRAP_CMD_ENABLE = 5'h1C;
  localparam logic SRAP_DIR_READ = 1'h1;

  // Highest register index; pointer saturates here
  localparam logic [9:0] SRAP_PTR_MAX = 10'h0FF;
  localparam logic [9:0] SRAP_PTR_RESET = 10'h000;

  localparam logic [3:0] SRAP_SPI_LAST_BIT = 4'hF;
  localparam logic [3:0] SRAP_I2C_LAST_BIT = 4'h7;
  localparam logic [3:0] SRAP_I2C_BYTE_BITS = 4'h8;

  // Upper five bits of the two-wire bus address
  localparam logic [4:0] SRAP_I2C_ADDR_HI = 5'h0B;

  // Synchroniser lanes
  localparam int unsigned SRAP_SYNC_W = 7;
  localparam int unsigned SRAP_S_CS = 0;
  localparam int unsigned SRAP_S_SCLK = 1;
  localparam int unsigned SRAP_S_DIN = 2;
  localparam int unsigned SRAP_S_SCL = 3;
  localparam int unsigned SRAP_S_SDA = 4;
  localparam int unsigned SRAP_S_AS0 = 5;
  localparam int unsigned SRAP_S_AS1 = 6;
  localparam logic [6:0] SRAP_SYNC_RESET = 7'h7B;

  typedef struct packed {
    logic wr;
    logic [9:0] addr;
    logic [15:0] data;
  } srap_reg_t;

  localparam srap_reg_t SRAP_REG_RESET = '{wr: 1'b0, addr: 10'h000, data: 16'h0000};

  typedef enum logic [1:0] {SPI_CMD, SPI_WR, SPI_RD, SPI_IGNORE} srap_spi_state_t;
  typedef enum logic [1:0] {I2C_IDLE, I2C_ADDR, I2C_WDATA, I2C_RDATA} srap_i2c_state_t;

endpackage : srap_pkg

// ### srap_serial_port.sv
`timescale 1ns/1ps

module srap_serial_port (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_din_i,
  output logic spi_dout_o,
  output logic spi_dout_oe_o,
  output srap_pkg::srap_reg_t spi_reg_o,
  input wire logic [15:0] spi_rd_data_i,
  input wire logic i2c_scl_i,
  input wire logic i2c_sda_i,
  output logic i2c_sda_o,
  output logic i2c_sda_oe_o,
  input wire logic bus_address_select_0_i,
  input wire logic bus_address_select_1_i,
  output srap_pkg::srap_reg_t i2c_reg_o,
  input wire logic [15:0] i2c_rd_data_i
);
  import srap_pkg::*;

  // Saturating pointer step shared by both variants
  function automatic logic [9:0] srap_step(input logic [9:0] ptr);
    srap_step = (ptr == SRAP_PTR_MAX) ? ptr : ptr + 10'h001;
  endfunction : srap_step

  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic [6:0] last_reg;

  // Two-flop synchronisers; edges are found only on the second stage
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_reg <= SRAP_SYNC_RESET;
      sync2_reg <= SRAP_SYNC_RESET;
      last_reg <= SRAP_SYNC_RESET;
    end else begin
      sync1_reg <= {bus_address_select_1_i, bus_address_select_0_i, i2c_sda_i, i2c_scl_i,
                    spi_din_i, spi_sclk_i, spi_cs_n_i};
      sync2_reg <= sync1_reg;
      last_reg <= sync2_reg;
    end
  end

  wire cs_n = sync2_reg[SRAP_S_CS];
  wire din = sync2_reg[SRAP_S_DIN];
  wire sclk_rise = sync2_reg[SRAP_S_SCLK] & ~last_reg[SRAP_S_SCLK];
  wire sclk_fall = ~sync2_reg[SRAP_S_SCLK] & last_reg[SRAP_S_SCLK];
  wire scl = sync2_reg[SRAP_S_SCL];
  wire sda = sync2_reg[SRAP_S_SDA];
  wire scl_rise = scl & ~last_reg[SRAP_S_SCL];
  wire scl_fall = ~scl & last_reg[SRAP_S_SCL];
  wire i2c_start = scl & last_reg[SRAP_S_SCL] & ~sda & last_reg[SRAP_S_SDA];
  wire i2c_stop = scl & last_reg[SRAP_S_SCL] & sda & ~last_reg[SRAP_S_SDA];

  // SPI variant
  srap_spi_state_t spi_state_reg;
  logic [3:0] spi_cnt_reg;
  logic [15:0] spi_in_reg;
  logic [15:0] spi_out_reg;
  logic [9:0] spi_ptr_reg;
  srap_reg_t spi_reg_reg;
  logic spi_dout_reg;
  logic spi_oe_reg;

  wire [15:0] spi_word = {spi_in_reg[14:0], din};
  wire spi_word_done = sclk_rise & (spi_cnt_reg == SRAP_SPI_LAST_BIT);
  wire spi_cmd_ok = spi_word[SRAP_CMD_EN_HI:SRAP_CMD_EN_LO] == SRAP_CMD_ENABLE;
  wire spi_cmd_rd = spi_word[SRAP_CMD_DIR_BIT] == SRAP_DIR_READ;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      spi_state_reg <= SPI_CMD;
      spi_cnt_reg <= 4'h0;
      spi_in_reg <= 16'h0000;
      spi_out_reg <= 16'h0000;
      spi_ptr_reg <= SRAP_PTR_RESET;
      spi_reg_reg <= SRAP_REG_RESET;
      spi_dout_reg <= 1'b0;
      spi_oe_reg <= 1'b0;
    end else if (cs_n) begin
      // Deselect drops any partial word and ends a read
      spi_state_reg <= SPI_CMD;
      spi_cnt_reg <= 4'h0;
      spi_oe_reg <= 1'b0;
      spi_reg_reg.wr <= 1'b0;
      spi_reg_reg.addr <= spi_ptr_reg;
    end else begin
      spi_reg_reg.wr <= 1'b0;
      spi_reg_reg.addr <= spi_ptr_reg;
      if (sclk_rise) begin
        spi_in_reg <= spi_word;
        spi_cnt_reg <= spi_cnt_reg + 4'h1;
      end
      if (spi_word_done) begin
        case (spi_state_reg)
          SPI_CMD: begin
            spi_ptr_reg <= spi_word[SRAP_ADDR_W-1:0];
            if (!spi_cmd_ok) begin
              spi_state_reg <= SPI_IGNORE;
            end else if (spi_cmd_rd) begin
              spi_state_reg <= SPI_RD;
            end else begin
              spi_state_reg <= SPI_WR;
            end
          end
          SPI_WR: begin
            spi_reg_reg.wr <= 1'b1;
            spi_reg_reg.data <= spi_word;
            spi_ptr_reg <= srap_step(spi_ptr_reg);
            if (spi_ptr_reg == SRAP_PTR_MAX) begin
              spi_state_reg <= SPI_IGNORE;
            end
          end
          SPI_RD: begin
            spi_ptr_reg <= srap_step(spi_ptr_reg);
          end
          default: begin
            spi_state_reg <= SPI_IGNORE;
          end
        endcase
      end
      if (sclk_fall && spi_state_reg == SPI_RD) begin
        spi_oe_reg <= 1'b1;
        if (spi_cnt_reg == 4'h0) begin
          // Word boundary: fetch the register now pointed at
          spi_out_reg <= spi_rd_data_i;
          spi_dout_reg <= spi_rd_data_i[SRAP_WORD_W-1];
        end else begin
          spi_out_reg <= {spi_out_reg[14:0], 1'b0};
          spi_dout_reg <= spi_out_reg[SRAP_WORD_W-2];
        end
      end
    end
  end

  assign spi_dout_o = spi_dout_reg;
  assign spi_dout_oe_o = spi_oe_reg;
  assign spi_reg_o = spi_reg_reg;

  // Two-wire variant: only ever answers, never starts anything
  srap_i2c_state_t i2c_state_reg;
  logic [3:0] i2c_cnt_reg;
  logic [7:0] i2c_sh_reg;
  logic [7:0] i2c_hold_reg;
  logic [9:0] i2c_ptr_reg;
  srap_reg_t i2c_reg_reg;
  logic i2c_byte_done_reg;
  logic i2c_ack_reg;
  logic i2c_first_reg;
  logic i2c_hi_reg;
  logic i2c_full_reg;
  logic i2c_oe_reg;

  wire [6:0] i2c_my_addr = {SRAP_I2C_ADDR_HI, sync2_reg[SRAP_S_AS1], sync2_reg[SRAP_S_AS0]};
  wire i2c_match = i2c_sh_reg[7:1] == i2c_my_addr;
  wire i2c_rd_dir = i2c_sh_reg[0] == SRAP_DIR_READ;
  wire [7:0] i2c_tx_byte = i2c_hi_reg ? i2c_rd_data_i[15:8] : i2c_rd_data_i[7:0];
  wire [7:0] i2c_tx_next = {i2c_sh_reg[6:0], 1'b0};

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      i2c_state_reg <= I2C_IDLE;
      i2c_cnt_reg <= 4'h0;
      i2c_sh_reg <= 8'h00;
      i2c_hold_reg <= 8'h00;
      i2c_ptr_reg <= SRAP_PTR_RESET;
      i2c_reg_reg <= SRAP_REG_RESET;
      i2c_byte_done_reg <= 1'b0;
      i2c_ack_reg <= 1'b0;
      i2c_first_reg <= 1'b0;
      i2c_hi_reg <= 1'b1;
      i2c_full_reg <= 1'b0;
      i2c_oe_reg <= 1'b0;
    end else begin
      i2c_reg_reg.wr <= 1'b0;
      i2c_reg_reg.addr <= i2c_ptr_reg;
      if (i2c_stop) begin
        i2c_state_reg <= I2C_IDLE;
        i2c_oe_reg <= 1'b0;
      end else if (i2c_start) begin
        i2c_state_reg <= I2C_ADDR;
        i2c_cnt_reg <= 4'h0;
        i2c_byte_done_reg <= 1'b0;
        i2c_ack_reg <= 1'b0;
        i2c_oe_reg <= 1'b0;
      end else if (scl_rise && i2c_state_reg != I2C_IDLE) begin
        if (i2c_ack_reg) begin
          // Master no-acknowledge ends a read
          if (i2c_state_reg == I2C_RDATA && sda) begin
            i2c_state_reg <= I2C_IDLE;
          end
        end else if (i2c_state_reg == I2C_RDATA) begin
          i2c_cnt_reg <= i2c_cnt_reg + 4'h1;
        end else begin
          i2c_sh_reg <= {i2c_sh_reg[6:0], sda};
          i2c_cnt_reg <= i2c_cnt_reg + 4'h1;
          i2c_byte_done_reg <= i2c_cnt_reg == SRAP_I2C_LAST_BIT;
        end
      end else if (scl_fall && i2c_state_reg != I2C_IDLE) begin
        // All SDA changes happen just after SCL falls
        if (i2c_byte_done_reg) begin
          i2c_byte_done_reg <= 1'b0;
          i2c_cnt_reg <= 4'h0;
          i2c_ack_reg <= 1'b1;
          i2c_oe_reg <= 1'b1;
          if (i2c_state_reg == I2C_ADDR) begin
            if (!i2c_match) begin
              i2c_state_reg <= I2C_IDLE;
              i2c_ack_reg <= 1'b0;
              i2c_oe_reg <= 1'b0;
            end else if (i2c_rd_dir) begin
              i2c_state_reg <= I2C_RDATA;
              i2c_hi_reg <= 1'b1;
            end else begin
              i2c_state_reg <= I2C_WDATA;
              i2c_first_reg <= 1'b1;
            end
          end else if (i2c_first_reg) begin
            i2c_ptr_reg <= {2'b00, i2c_sh_reg};
            i2c_first_reg <= 1'b0;
            i2c_hi_reg <= 1'b1;
            i2c_full_reg <= 1'b0;
          end else if (i2c_hi_reg) begin
            i2c_hold_reg <= i2c_sh_reg;
            i2c_hi_reg <= 1'b0;
          end else begin
            // Past the last register, pairs are acknowledged but dropped
            i2c_reg_reg.wr <= ~i2c_full_reg;
            i2c_reg_reg.data <= {i2c_hold_reg, i2c_sh_reg};
            i2c_ptr_reg <= srap_step(i2c_ptr_reg);
            i2c_full_reg <= i2c_full_reg | (i2c_ptr_reg == SRAP_PTR_MAX);
            i2c_hi_reg <= 1'b1;
          end
        end else if (i2c_ack_reg) begin
          i2c_ack_reg <= 1'b0;
          i2c_oe_reg <= 1'b0;
          if (i2c_state_reg == I2C_RDATA) begin
            i2c_sh_reg <= i2c_tx_byte;
            i2c_oe_reg <= ~i2c_tx_byte[7];
            i2c_cnt_reg <= 4'h0;
            i2c_hi_reg <= ~i2c_hi_reg;
            if (!i2c_hi_reg) begin
              i2c_ptr_reg <= srap_step(i2c_ptr_reg);
            end
          end
        end else if (i2c_state_reg == I2C_RDATA) begin
          if (i2c_cnt_reg == SRAP_I2C_BYTE_BITS) begin
            i2c_oe_reg <= 1'b0;
            i2c_ack_reg <= 1'b1;
          end else begin
            i2c_sh_reg <= i2c_tx_next;
            i2c_oe_reg <= ~i2c_tx_next[7];
          end
        end
      end
    end
  end

  // Open drain: the line is only ever pulled low
  assign i2c_sda_o = 1'b0;
  assign i2c_sda_oe_o = i2c_oe_reg;
  assign i2c_reg_o = i2c_reg_reg;

endmodule : srap_serial_port

// ### srap_serial_port_assertions.sv
`timescale 1ns/1ps
module srap_serial_port_assertions (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_dout_o,
  input wire logic spi_dout_oe_o,
  input wire srap_pkg::srap_reg_t spi_reg_o,
  input wire logic i2c_scl_i,
  input wire logic i2c_sda_oe_o,
  input wire srap_pkg::srap_reg_t i2c_reg_o
);
  import srap_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_oe_idle; spi_cs_n_i [*6] |-> !spi_dout_oe_o; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("dout driven while deselected");
  property p_oe_start; $rose(spi_dout_oe_o) |-> !spi_cs_n_i && !$past(spi_sclk_i, 2); endproperty
  a_oe_start: assert property (p_oe_start) else $error("dout enabled off a fall");
  // Pins pass two flops, so the launching fall is two samples back
  property p_dout_fall; spi_dout_oe_o && $changed(spi_dout_o) |-> !$past(spi_sclk_i, 2); endproperty
  a_dout_fall: assert property (p_dout_fall) else $error("dout moved off a fall");
  property p_wr_gap; spi_reg_o.wr |=> !spi_reg_o.wr [*8]; endproperty
  a_wr_gap: assert property (p_wr_gap) else $error("write pulses too close");
  property p_wr_next;
    spi_reg_o.wr && spi_reg_o.addr != SRAP_PTR_MAX |=>
      spi_reg_o.addr == $past(spi_reg_o.addr) + 10'h001;
  endproperty
  a_wr_next: assert property (p_wr_next) else $error("pointer did not advance");
  property p_wr_sat; spi_reg_o.wr && spi_reg_o.addr == SRAP_PTR_MAX |=> spi_reg_o.addr == SRAP_PTR_MAX; endproperty
  a_wr_sat: assert property (p_wr_sat) else $error("pointer wrapped");
  property p_wr_idle; spi_cs_n_i [*8] |-> !spi_reg_o.wr; endproperty
  a_wr_idle: assert property (p_wr_idle) else $error("write while deselected");
  property p_sda_edge; $changed(i2c_sda_oe_o) |-> !$past(i2c_scl_i, 2); endproperty
  a_sda_edge: assert property (p_sda_edge) else $error("data line moved with clock high");
  property p_scl_high; i2c_scl_i [*8] |-> !i2c_sda_oe_o; endproperty
  a_scl_high: assert property (p_scl_high) else $error("data line held on idle bus");
  c_spi_wr: cover property (spi_reg_o.wr);
  c_spi_rd: cover property ($rose(spi_dout_oe_o));
  c_i2c_ack: cover property ($rose(i2c_sda_oe_o));
  c_i2c_wr: cover property (i2c_reg_o.wr);
endmodule : srap_serial_port_assertions

bind srap_serial_port srap_serial_port_assertions srap_serial_port_assertions_inst (
  .ref_clk_i, .reset_n_i, .spi_cs_n_i, .spi_sclk_i, .spi_dout_o, .spi_dout_oe_o,
  .spi_reg_o, .i2c_scl_i, .i2c_sda_oe_o, .i2c_reg_o
);

// ### srap_host.sv
`timescale 1ns/1ps
module srap_host (
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o,
  input wire logic dout_i,
  output logic scl_o,
  output logic sda_pull_o,
  input wire logic sda_i
);
  logic sclk_idle = 1'b0;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // Idle level set first so no stray edge follows the select; with idle low, the deselect adds a fall before CS rises
  task automatic spi_cs(input logic lvl);
    sclk_o = sclk_idle;
    #200 cs_n_o = lvl;
    din_o = ~din_o;
    #200;
  endtask : spi_cs
  task automatic spi_word(input logic [15:0] w, input int n, output logic [15:0] r);
    for (int i = 15; i > 15 - n; i--) begin
      sclk_o = 1'b0;
      din_o = w[i];
      #200 sclk_o = 1'b1;
      #200 r[i] = dout_i;
    end
  endtask : spi_word
  // Data moves late in the low phase, after the device has let go
  task automatic i2c_bit(input logic b, output logic r);
    #200 sda_pull_o = ~b;
    #50 scl_o = 1'b1;
    #150 r = sda_i;
    scl_o = 1'b0;
  endtask : i2c_bit
  task automatic i2c_byte(input logic [7:0] b, input logic ack_in, output logic [7:0] r,
                          output logic ack);
    for (int i = 7; i >= 0; i--) i2c_bit(b[i], r[i]);
    i2c_bit(ack_in, ack);
  endtask : i2c_byte
  task automatic i2c_start;
    #200 sda_pull_o = 1'b0;
    #50 scl_o = 1'b1;
    #100 sda_pull_o = 1'b1;
    #100 scl_o = 1'b0;
  endtask : i2c_start
  task automatic i2c_stop;
    #200 sda_pull_o = 1'b1;
    #50 scl_o = 1'b1;
    #100 sda_pull_o = 1'b0;
    #200;
  endtask : i2c_stop
  // Clock drops with the data line high, which is neither start nor stop
  task automatic i2c_scl_low;
    #200 scl_o = 1'b0;
  endtask : i2c_scl_low
endmodule : srap_host

// ### srap_serial_port_bench.sv
`timescale 1ns/1ps
module srap_serial_port_bench;
  import srap_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic as0 = 1'b0;
  logic as1 = 1'b0;
  logic cs_n, sclk, din, dout, dout_oe, scl, sda_pull, sda_o, sda_oe;
  srap_reg_t spi_reg, i2c_reg;
  // Open-drain line: low while either side pulls it
  wire sda = !sda_pull && !(sda_oe && !sda_o);
  wire [15:0] spi_rd = 16'hC000 ^ {6'h00, spi_reg.addr};
  wire [15:0] i2c_rd = 16'h3500 ^ {6'h00, i2c_reg.addr};
  wire dout_line = dout_oe ? dout : 1'bz;
  int fails = 0;
  int compares = 0;
  logic [25:0] spi_q[$];
  logic [25:0] i2c_q[$];
  always #25 ref_clk_i = ~ref_clk_i;
  // Sampled mid-cycle, away from the edge that launches the pulse
  always @(negedge ref_clk_i) begin
    if (spi_reg.wr === 1'b1) spi_q.push_back({spi_reg.addr, spi_reg.data});
    if (i2c_reg.wr === 1'b1) i2c_q.push_back({i2c_reg.addr, i2c_reg.data});
  end
  srap_serial_port srap_serial_port_inst (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk),
    .spi_din_i(din), .spi_dout_o(dout), .spi_dout_oe_o(dout_oe), .spi_reg_o(spi_reg),
    .spi_rd_data_i(spi_rd), .i2c_scl_i(scl), .i2c_sda_i(sda),
    .i2c_sda_o(sda_o), .i2c_sda_oe_o(sda_oe), .bus_address_select_0_i(as0),
    .bus_address_select_1_i(as1), .i2c_reg_o(i2c_reg),
    .i2c_rd_data_i(i2c_rd)
  );
  srap_host srap_host_inst (
    .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din), .dout_i(dout_line), .scl_o(scl),
    .sda_pull_o(sda_pull), .sda_i(sda)
  );
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  task automatic frame(input logic [15:0] cmd, input logic [15:0] w, input int n);
    logic [15:0] r;
    srap_host_inst.spi_cs(1'b0);
    srap_host_inst.spi_word(cmd, 16, r);
    srap_host_inst.spi_word(w, n, r);
    srap_host_inst.spi_cs(1'b1);
  endtask : frame
  task automatic spi_write;
    logic [15:0] r;
    srap_host_inst.spi_cs(1'b0);
    srap_host_inst.spi_word(16'hE0FE, 16, r);
    srap_host_inst.spi_word(16'h1111, 16, r);
    srap_host_inst.spi_word(16'h2222, 16, r);
    srap_host_inst.spi_word(16'h3333, 16, r);
    srap_host_inst.spi_cs(1'b1);
    frame(16'hE010, 16'hABCD, 8);
    frame(16'hF010, 16'h5555, 16);
    check(spi_q.size(), 2);
    check(spi_q[0], {10'h0FE, 16'h1111});
    check(spi_q[1], {10'h0FF, 16'h2222});
  endtask : spi_write
  task automatic spi_read;
    logic [15:0] r;
    srap_host_inst.sclk_idle = 1'b1;
    srap_host_inst.spi_cs(1'b0);
    srap_host_inst.spi_word(16'hE4FE, 16, r);
    check(dout_oe, 1'b0);
    srap_host_inst.spi_word(16'h0000, 16, r);
    check(r, 16'hC0FE);
    srap_host_inst.spi_word(16'h0000, 16, r);
    check(r, 16'hC0FF);
    srap_host_inst.spi_word(16'h0000, 16, r);
    check(r, 16'hC0FF);
    srap_host_inst.spi_cs(1'b1);
    check(dout_oe, 1'b0);
    srap_host_inst.sclk_idle = 1'b0;
    srap_host_inst.spi_cs(1'b0);
    srap_host_inst.spi_word(16'hE410, 16, r);
    srap_host_inst.spi_word(16'h0000, 16, r);
    check(r, 16'hC010);
    srap_host_inst.spi_cs(1'b1);
  endtask : spi_read
  task automatic i2c_run;
    logic [7:0] r;
    logic ack;
    logic [7:0] exp_rd [6] = '{8'h35, 8'hFE, 8'h35, 8'hFF, 8'h35, 8'hFF};
    logic [7:0] wr_b [6] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
    for (int a = 0; a < 4; a++) begin
      as0 = a[0];
      as1 = a[1];
      i2c_q.delete();
      srap_host_inst.i2c_start();
      srap_host_inst.i2c_byte({5'h0B, a[1:0], 1'b0}, 1'b1, r, ack);
      check(ack, 1'b0);
      srap_host_inst.i2c_byte(8'h20, 1'b1, r, ack);
      srap_host_inst.i2c_byte(8'hAB, 1'b1, r, ack);
      srap_host_inst.i2c_byte(8'hCD, 1'b1, r, ack);
      srap_host_inst.i2c_stop();
      check(i2c_q[0], {10'h020, 16'hABCD});
      srap_host_inst.i2c_start();
      srap_host_inst.i2c_byte({5'h0B, ~a[1:0], 1'b0}, 1'b1, r, ack);
      check(ack, 1'b1);
      srap_host_inst.i2c_stop();
    end
    i2c_q.delete();
    srap_host_inst.i2c_start();
    srap_host_inst.i2c_byte(8'h5E, 1'b1, r, ack);
    srap_host_inst.i2c_byte(8'hFE, 1'b1, r, ack);
    for (int i = 0; i < 6; i++) srap_host_inst.i2c_byte(wr_b[i], 1'b1, r, ack);
    check(ack, 1'b0);
    srap_host_inst.i2c_stop();
    check(i2c_q.size(), 2);
    check(i2c_q[0], {10'h0FE, 16'h1122});
    check(i2c_q[1], {10'h0FF, 16'h3344});
    srap_host_inst.i2c_start();
    srap_host_inst.i2c_byte(8'h5E, 1'b1, r, ack);
    srap_host_inst.i2c_byte(8'hFE, 1'b1, r, ack);
    srap_host_inst.i2c_start();
    srap_host_inst.i2c_byte(8'h5F, 1'b1, r, ack);
    check(ack, 1'b0);
    for (int i = 0; i < 6; i++) begin
      srap_host_inst.i2c_byte(8'hFF, i == 5, r, ack);
      check(r, exp_rd[i]);
    end
    srap_host_inst.i2c_stop();
    check(sda, 1'b1);
    i2c_q.delete();
    srap_host_inst.i2c_start();
    srap_host_inst.i2c_byte(8'h5E, 1'b1, r, ack);
    srap_host_inst.i2c_byte(8'h10, 1'b1, r, ack);
    srap_host_inst.i2c_byte(8'h77, 1'b1, r, ack);
    srap_host_inst.i2c_stop();
    srap_host_inst.i2c_scl_low();
    srap_host_inst.i2c_byte(8'h88, 1'b1, r, ack);
    check(ack, 1'b1);
    srap_host_inst.i2c_stop();
    check(i2c_q.size(), 0);
  endtask : i2c_run
  initial begin
    repeat (12) @(posedge ref_clk_i);
    #1 reset_n_i = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1;
    spi_write();
    spi_read();
    i2c_run();
    finish_test();
  end
  initial begin
    #1ms;
    fails++;
    finish_test();
  end
endmodule : srap_serial_port_bench
